/* rtl/spc_pkg.sv */
// Package for the SPI pin-mode, receive DMA and wait-stop control block.
// Assumes a 32-bit APB master on the same 125 MHz clock.
package spc_pkg;

   // ---------------------------------------------------------------
   // Register offsets (printed offset 2h is not a word multiple)
   // ---------------------------------------------------------------
   localparam logic [3:0]  CTRL_IDX     = 4'h1;
   localparam logic [3:0]  RATE_IDX     = 4'h2;
   localparam logic [3:0]  STAT_IDX     = 4'h3;
   localparam logic [11:0] CTRL_ADDR    = 12'h004;
   localparam logic [11:0] RATE_ADDR    = 12'h008;
   localparam logic [11:0] STAT_ADDR    = 12'h00C;

   // ---------------------------------------------------------------
   // Field positions and reset values
   // ---------------------------------------------------------------
   localparam int CTRL_PIN_SEL_BIT  = 0;
   localparam int CTRL_STOP_WAI_BIT = 1;
   localparam int CTRL_RX_DMA_BIT   = 2;
   localparam int CTRL_OUT_EN_BIT   = 3;
   localparam int CTRL_MASTER_BIT   = 4;
   localparam int CTRL_SYS_EN_BIT   = 6;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] RATE_RESET = 8'h00;
   localparam logic [7:0] RATE_MASK  = 8'h7F;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic o;
      logic oe;
   } spc_pin_s;

   typedef enum logic [1:0] {
      SPC_RUN  = 2'b00,
      SPC_STOP = 2'b01
   } spc_state_e;

endpackage

/* rtl/spc_ctrl.sv */
// SPI control block: pin routing, receive DMA request, wait-mode stop,
// baud rate register and a two-entry receive buffer.
// Assumes an APB master and a shift engine on ref_clk_i; pins are synced.
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module spc_ctrl (
   input  wire logic        ref_clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        clk_en_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   input  wire logic        wait_mode_i,
   input  wire logic        miso_i,
   output logic             miso_o,
   output logic             miso_oe_o,
   input  wire logic        mosi_i,
   output logic             mosi_o,
   output logic             mosi_oe_o,
   input  wire logic        shift_out_i,
   output logic             shift_in_o,
   output logic             core_clk_en_o,
   output logic      [6:0]  rate_sel_o,
   input  wire logic        rx_valid_i,
   input  wire logic [7:0]  rx_data_i,
   output logic             rx_ready_o,
   output logic             rx_buffer_full_flag_o,
   input  wire logic        rx_take_i,
   output logic      [7:0]  rx_data_o,
   output logic             rx_dma_req_o,
   output logic             rx_irq_req_o
);

   // ---------------------------------------------------------------
   // Registers and synchronisers
   // ---------------------------------------------------------------
   logic [7:0]  ctrl_r;
   logic [7:0]  rate_r;
   logic [1:0]  miso_sync_r;
   logic [1:0]  mosi_sync_r;
   logic [1:0]  wait_sync_r;
   logic [7:0]  buf_r [2];
   logic        wr_ptr_r;
   logic        rd_ptr_r;
   logic [1:0]  count_r;
   spc_pkg::spc_state_e state_r;
   spc_pkg::spc_state_e state_nxt;

   wire logic access    = psel_i & penable_i;
   wire logic wr_acc    = access & pwrite_i;
   // One comparator shape serves every register, so the three hits
   // cannot drift apart when an address constant changes.
   function automatic logic addr_hit(input logic [11:0] addr,
                                     input logic [11:0] reg_addr);
      addr_hit = (addr == reg_addr);
   endfunction

   wire logic hit_ctrl  = addr_hit(paddr_i, spc_pkg::CTRL_ADDR);
   wire logic hit_rate  = addr_hit(paddr_i, spc_pkg::RATE_ADDR);
   wire logic hit_stat  = addr_hit(paddr_i, spc_pkg::STAT_ADDR);
   wire logic unmapped  = ~(hit_ctrl | hit_rate | hit_stat);

   wire logic pin_sel   = ctrl_r[spc_pkg::CTRL_PIN_SEL_BIT];
   wire logic stop_wai  = ctrl_r[spc_pkg::CTRL_STOP_WAI_BIT];
   wire logic dma_en    = ctrl_r[spc_pkg::CTRL_RX_DMA_BIT];
   wire logic sw_oe     = ctrl_r[spc_pkg::CTRL_OUT_EN_BIT];
   wire logic master    = ctrl_r[spc_pkg::CTRL_MASTER_BIT];
   wire logic sys_en    = ctrl_r[spc_pkg::CTRL_SYS_EN_BIT];
   wire logic miso_s    = miso_sync_r[1];
   wire logic mosi_s    = mosi_sync_r[1];
   wire logic wait_s    = wait_sync_r[1];

   // ---------------------------------------------------------------
   // Wait-mode clock gate
   // ---------------------------------------------------------------
   // The engine only loses its enable, so every flop keeps its value
   // and carries on where it stopped once wait mode ends.
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         spc_pkg::SPC_RUN: begin
            if (wait_s & stop_wai) begin
               state_nxt = spc_pkg::SPC_STOP;
            end
         end
         spc_pkg::SPC_STOP: begin
            if (!wait_s | !stop_wai) begin
               state_nxt = spc_pkg::SPC_RUN;
            end
         end
         default: begin
            state_nxt = spc_pkg::SPC_RUN;
         end
      endcase
   end

   wire logic running = (state_r == spc_pkg::SPC_RUN);
   wire logic stopped = (state_r == spc_pkg::SPC_STOP);
   assign core_clk_en_o = running & clk_en_i;

   // ---------------------------------------------------------------
   // Pin routing
   // ---------------------------------------------------------------
   spc_pkg::spc_pin_s miso_pin;
   spc_pkg::spc_pin_s mosi_pin;

   // Normal master drives MOSI; single-wire master shares MOSI.
   assign mosi_pin.oe = master & (~pin_sel | sw_oe) & sys_en;
   // Normal slave drives MISO; single-wire slave shares MISO.
   assign miso_pin.oe = ~master & (~pin_sel | sw_oe) & sys_en;
   assign mosi_pin.o  = shift_out_i;
   assign miso_pin.o  = shift_out_i;

   wire logic sel_mosi_in = (master & pin_sel) | (~master & ~pin_sel);
   assign shift_in_o = sel_mosi_in ? mosi_s : miso_s;

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         miso_o    <= 1'b0;
         miso_oe_o <= 1'b0;
         mosi_o    <= 1'b0;
         mosi_oe_o <= 1'b0;
      end else if (clk_en_i) begin
         miso_o    <= miso_pin.o;
         miso_oe_o <= miso_pin.oe;
         mosi_o    <= mosi_pin.o;
         mosi_oe_o <= mosi_pin.oe;
      end
   end

   // ---------------------------------------------------------------
   // Receive buffer and DMA request
   // ---------------------------------------------------------------
   wire logic push = rx_valid_i & rx_ready_o & running;
   wire logic pop  = rx_take_i & (count_r != 2'd0) & running;
   // A push and a pop in one cycle leave the count unchanged.
   wire logic [1:0] count_nxt = count_r + {1'b0, push} - {1'b0, pop};

   assign rx_ready_o            = (count_r != 2'd2);
   assign rx_buffer_full_flag_o = (count_r != 2'd0);
   assign rx_data_o             = buf_r[rd_ptr_r];
   wire logic rx_pend = rx_buffer_full_flag_o & sys_en;
   assign rx_dma_req_o = dma_en & rx_pend;
   assign rx_irq_req_o = ~dma_en & rx_buffer_full_flag_o;

   always_ff @(posedge ref_clk_i) begin
      if (clk_en_i & push) begin
         buf_r[wr_ptr_r] <= rx_data_i;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_ptr_r <= 1'b0;
         rd_ptr_r <= 1'b0;
         count_r  <= 2'd0;
      end else if (clk_en_i) begin
         if (push) begin
            wr_ptr_r <= ~wr_ptr_r;
         end
         if (pop) begin
            rd_ptr_r <= ~rd_ptr_r;
         end
         count_r <= count_nxt;
      end
   end

   // ---------------------------------------------------------------
   // APB slave
   // ---------------------------------------------------------------
   assign pready_o  = 1'b1;
   assign pslverr_o = access & unmapped;
   assign rate_sel_o = rate_r[6:0];

   always_comb begin
      prdata_o = 32'h0000_0000;
      if (hit_ctrl) begin
         prdata_o = {24'h00_0000, ctrl_r};
      end
      if (hit_rate) begin
         prdata_o = {24'h00_0000, rate_r};
      end
      if (hit_stat) begin
         prdata_o = {29'h000_0000, stopped, count_r};
      end
   end

   // ---------------------------------------------------------------
   // Input synchronisers
   // ---------------------------------------------------------------
   // Pins and the wait request are asynchronous to the bus clock, so
   // only the second flop of each pair is read by the logic.
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         miso_sync_r <= 2'b00;
         mosi_sync_r <= 2'b00;
         wait_sync_r <= 2'b00;
      end else if (clk_en_i) begin
         miso_sync_r <= {miso_sync_r[0], miso_i};
         mosi_sync_r <= {mosi_sync_r[0], mosi_i};
         wait_sync_r <= {wait_sync_r[0], wait_mode_i};
      end
   end

   // ---------------------------------------------------------------
   // State and registers
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_r <= spc_pkg::SPC_RUN;
      end else if (clk_en_i) begin
         state_r <= state_nxt;
      end
   end

   // Register writes stay live while the engine is stopped, so software
   // can retune the rate before leaving wait mode.
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl_r <= spc_pkg::CTRL_RESET;
         rate_r <= spc_pkg::RATE_RESET;
      end else if (clk_en_i) begin
         if (wr_acc & hit_ctrl) begin
            ctrl_r <= pwdata_i[7:0];
         end
         // Bus writes reach the rate register even mid-transfer.
         if (wr_acc & hit_rate) begin
            rate_r <= pwdata_i[7:0] & spc_pkg::RATE_MASK;
         end
      end
   end

endmodule
`default_nettype wire

/* dv/spc_ctrl_asserts.sv */
// Checker for spc_ctrl, fed only by its top-level ports through bind.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ns
`default_nettype none
module spc_ctrl_asserts (
   input wire logic        ref_clk_i,
   input wire logic        rst_n_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic        pready_o,
   input wire logic        wait_mode_i,
   input wire logic        miso_oe_o,
   input wire logic        mosi_oe_o,
   input wire logic        core_clk_en_o,
   input wire logic [6:0]  rate_sel_o,
   input wire logic        rx_buffer_full_flag_o,
   input wire logic        rx_dma_req_o,
   input wire logic        rx_irq_req_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   wire rate_acc = psel_i && penable_i && paddr_i == spc_pkg::RATE_ADDR;
   a_dma_irq_excl: assert property (!(rx_dma_req_o && rx_irq_req_o))
      else $error("dma and irq requests together");
   a_dma_needs_full: assert property (rx_dma_req_o |-> rx_buffer_full_flag_o)
      else $error("dma request without full flag");
   a_irq_needs_full: assert property (rx_irq_req_o |-> rx_buffer_full_flag_o)
      else $error("irq request without full flag");
   // The synchroniser and state flop delay the stop by three edges; the check allows two to four.
   a_stop_on_wait: assert property (!core_clk_en_o |-> $past(wait_mode_i, 2)
      || $past(wait_mode_i, 3) || $past(wait_mode_i, 4))
      else $error("clocks stopped outside wait");
   a_no_wait_state: assert property (psel_i && penable_i |-> pready_o)
      else $error("access phase not answered");
   a_rate_write: assert property (rate_acc && pwrite_i |=>
      rate_sel_o == 7'($past(pwdata_i))) else $error("rate write lost");
   a_rate_read: assert property (rate_acc && !pwrite_i |->
      prdata_o == {25'h0, rate_sel_o}) else $error("rate read wrong");
   a_one_driver: assert property (!(miso_oe_o && mosi_oe_o))
      else $error("both data pins driven");
   cover property (rx_dma_req_o);
   cover property (!core_clk_en_o);
   cover property (mosi_oe_o ##1 miso_oe_o);
endmodule
bind spc_ctrl spc_ctrl_asserts u_chk (.*);
`default_nettype wire

/* dv/spc_peer.sv */
// Far-side SPI device: answers 1 on MISO and 0 on MOSI while active.
// Assumes the bench resolves each shared pin from both drivers.
`timescale 1ns/1ns
`default_nettype none
module spc_peer (
   input  wire logic ref_clk_i,
   input  wire logic active_i,
   output logic      miso_o,
   output logic      mosi_o
);
   logic tog_r = 1'h0;
   always @(posedge ref_clk_i) tog_r <= ~tog_r;
   // Released lines toggle so that a stale level never passes for data.
   assign miso_o = active_i ? 1'h1 : tog_r;
   assign mosi_o = active_i ? 1'h0 : ~tog_r;
endmodule
`default_nettype wire

/* dv/tb_spi_pin_mode_dma_wait_ctrl.sv */
// Bench for spc_ctrl: registers over APB, pins, buffer, DMA and wait.
// Assumes spc_pkg, spc_ctrl, spc_peer and the checker are compiled.
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
   bad_count++; $display("ERROR %s exp %0h got %0h", n, e, g); end end
module tb_spi_pin_mode_dma_wait_ctrl;
   logic        ref_clk_i = 1'h0, rst_n_i = 1'h0, clk_en_i = 1'h1, err;
   logic        psel_i = 1'h0, penable_i = 1'h0, pwrite_i = 1'h0;
   logic        wait_mode_i = 1'h0, shift_out_i = 1'h0;
   logic        rx_valid_i = 1'h0, rx_take_i = 1'h0;
   logic [11:0] paddr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
   logic [7:0]  rx_data_i = 8'h00, rx_data_o;
   logic [6:0]  rate_sel_o;
   logic        pready_o, pslverr_o, miso_o, miso_oe_o, mosi_o, mosi_oe_o;
   logic        shift_in_o, core_clk_en_o, rx_ready_o, rx_buffer_full_flag_o;
   logic        rx_dma_req_o, rx_irq_req_o;
   wire logic   miso_i, mosi_i, p_miso, p_mosi;
   int          bad_count = 0, comparisons = 0;
   assign miso_i = miso_oe_o ? miso_o : p_miso;
   assign mosi_i = mosi_oe_o ? mosi_o : p_mosi;
   spc_ctrl u_dut (.*);
   spc_peer u_peer (.ref_clk_i(ref_clk_i), .active_i(1'h1),
                    .miso_o(p_miso), .mosi_o(p_mosi));
   initial forever #4 ref_clk_i = ~ref_clk_i;
   // -------------------------------------------------------------
   // Shared tasks
   // -------------------------------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk_i);
   endtask
   task automatic wrap_up;
      $display("TB: %0d compared, %0d bad", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic bound(input int n);
      if (n >= 20) begin
         bad_count++;
         wrap_up();
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge ref_clk_i);
      psel_i    <= 1'h1;
      pwrite_i  <= w;
      paddr_i   <= a;
      pwdata_i  <= d;
      @(posedge ref_clk_i);
      penable_i <= 1'h1;
      do begin @(posedge ref_clk_i); n++; end while (pready_o !== 1'h1 && n < 20);
      bound(n);
      rd = prdata_o;
      err = pslverr_o;
      psel_i    <= 1'h0;
      penable_i <= 1'h0;
   endtask
   task automatic push(input logic [7:0] d);
      int n = 0;
      @(posedge ref_clk_i);
      rx_valid_i <= 1'h1;
      rx_data_i  <= d;
      do begin @(posedge ref_clk_i); n++; end while (rx_ready_o !== 1'h1 && n < 20);
      bound(n);
      rx_valid_i <= 1'h0;
   endtask
   task automatic pop(input logic [7:0] d);
      `CHK("head", d, rx_data_o)
      @(posedge ref_clk_i);
      rx_take_i <= 1'h1;
      @(posedge ref_clk_i);
      rx_take_i <= 1'h0;
      cyc(1);
   endtask
   task automatic t_rate;
      apb(0, spc_pkg::RATE_ADDR, 32'h0);
      `CHK("rate_reset", 32'h0, rd)
      apb(1, spc_pkg::RATE_ADDR, 32'hFF);
      apb(0, spc_pkg::RATE_ADDR, 32'h0);
      `CHK("rate_rd", 32'h7F, rd)
      `CHK("rate_sel", 7'h7F, rate_sel_o)
      apb(0, 12'h010, 32'h0);
      `CHK("unmapped", 1'h1, err)
      $display("TB: rate test done");
   endtask
   task automatic t_pins;
      logic [7:0] cfg [6] = '{8'h50, 8'h40, 8'h51, 8'h59, 8'h41, 8'h49};
      logic [2:0] exp [6] = '{3'h5, 3'h2, 3'h0, 3'h5, 3'h1, 3'h3};
      shift_out_i <= 1'h1;
      for (int i = 0; i < 6; i++) begin
         apb(1, spc_pkg::CTRL_ADDR, {24'h0, cfg[i]});
         cyc(5);
         `CHK("pins", exp[i], {mosi_oe_o, miso_oe_o, shift_in_o})
         `CHK("pin_out", 2'h3, {mosi_o, miso_o})
      end
      $display("TB: pin test done");
   endtask
   task automatic t_dma;
      apb(1, spc_pkg::CTRL_ADDR, 32'h44);
      push(8'hA5);
      push(8'h5A);
      cyc(1);
      `CHK("full", 1'h0, rx_ready_o)
      `CHK("req", 2'h2, {rx_dma_req_o, rx_irq_req_o})
      apb(1, spc_pkg::CTRL_ADDR, 32'h04);
      cyc(1);
      `CHK("req", 2'h0, {rx_dma_req_o, rx_irq_req_o})
      apb(1, spc_pkg::CTRL_ADDR, 32'h40);
      cyc(1);
      `CHK("req", 2'h1, {rx_dma_req_o, rx_irq_req_o})
      pop(8'hA5);
      pop(8'h5A);
      `CHK("req", 2'h0, {rx_dma_req_o, rx_irq_req_o})
      $display("TB: dma test done");
   endtask
   task automatic t_wait;
      push(8'h3C);
      wait_mode_i <= 1'h1;
      cyc(5);
      `CHK("run", 1'h1, core_clk_en_o)
      apb(1, spc_pkg::CTRL_ADDR, 32'h42);
      cyc(5);
      `CHK("stop", 1'h0, core_clk_en_o)
      pop(8'h3C);
      apb(1, spc_pkg::RATE_ADDR, 32'h15);
      apb(0, spc_pkg::RATE_ADDR, 32'h0);
      `CHK("rate_rd", 32'h15, rd)
      apb(0, spc_pkg::STAT_ADDR, 32'h0);
      `CHK("stat", 32'h5, rd)
      `CHK("kept", 1'h1, rx_buffer_full_flag_o)
      wait_mode_i <= 1'h0;
      cyc(5);
      `CHK("run", 1'h1, core_clk_en_o)
      pop(8'h3C);
      $display("TB: wait test done");
   endtask
   initial begin
      cyc(16);
      rst_n_i <= 1'h1;
      t_rate();
      t_pins();
      t_dma();
      t_wait();
      wrap_up();
   end
endmodule
`default_nettype wire
